// [rtl/spi_cfg.svh]
// Timing constants and widths for the snoop and primary invalidate control.
// Included by the package and the top module; definitions only.
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

`define SPI_CLK_PERIOD_NS   8
`define SPI_INV_TENURE_CLKS 2
`define SPI_CPB_WINDOW_CLKS 3
`define SPI_SNOOP_RESP_CLKS 2
`define SPI_ADDR_W          32
`define SPI_LINE_OFFS_W     5

`endif

// [rtl/spi_pkg.sv]
// Types for the snoop and primary invalidate control.
// Needs spi_cfg.svh on the include path.
`include "spi_cfg.svh"

package spi_pkg;

  typedef enum logic [2:0] {
    SPI_IDLE,
    SPI_RETRY,
    SPI_REQ,
    SPI_TENURE,
    SPI_WINDOW,
    SPI_PCPB
  } spi_inv_state_t;

endpackage

// [rtl/spi_snoop_resp.sv]
// Snoop lookup and status response on the system bus side.
// Tag hit inputs are valid in the same clock as a global transfer start.
`timescale 1ns/1ps
`default_nettype none

module spi_snoop_resp
  import spi_pkg::*;
(
  input  wire  logic sys_clk,                 // System clock
  input  wire  logic reset,                   // Synchronous reset
  input  wire  logic lookup,                  // Global snoop lookup this cycle
  input  wire  logic main_cache_tag_hit,      // Main tag hit
  input  wire  logic main_cache_tag_modified, // Hit line is modified
  input  wire  logic processor_side_tag_hit,  // Processor-side tag hit
  input  wire  logic inv_busy,                // Invalidate already in progress
  output logic       snoop_shared_status,     // Shared status
  output logic       snoop_retry_status,      // Retry status
  output logic       snoop_copyback_status,   // Copyback status
  output logic       need_copyback,           // Pulse: copyback required
  output logic       need_invalidate          // Pulse: invalidate required
);

  logic any_hit;
  logic cpb_hit;
  logic inv_hit;
  logic busy_retry;

  assign any_hit    = lookup & (main_cache_tag_hit | processor_side_tag_hit);
  assign cpb_hit    = lookup & main_cache_tag_hit & main_cache_tag_modified;
  assign inv_hit    = lookup & processor_side_tag_hit;
  // A new invalidate cannot start while one runs: the snooping master is retried
  assign busy_retry = inv_hit & inv_busy;

  // ------------------------------------------------------------------
  // Status outputs, one clock after the lookup
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      snoop_shared_status   <= 1'b0;
      snoop_retry_status    <= 1'b0;
      snoop_copyback_status <= 1'b0;
      need_copyback         <= 1'b0;
      need_invalidate       <= 1'b0;
    end else begin
      snoop_shared_status   <= any_hit;
      snoop_retry_status    <= cpb_hit | busy_retry;
      snoop_copyback_status <= cpb_hit;
      need_copyback         <= cpb_hit;
      need_invalidate       <= inv_hit & ~inv_busy;
    end
  end

  property miss_quiet_p;
    @(posedge sys_clk) disable iff (reset)
      (lookup & ~main_cache_tag_hit & ~processor_side_tag_hit) |=>
        ~snoop_shared_status & ~snoop_retry_status & ~snoop_copyback_status;
  endproperty
  miss_quiet_a: assert property (miss_quiet_p) else $error("status set on snoop miss");

  property clean_shared_p;
    @(posedge sys_clk) disable iff (reset)
      (lookup & main_cache_tag_hit & ~main_cache_tag_modified & ~inv_busy) |=>
        snoop_shared_status & ~snoop_retry_status;
  endproperty
  clean_shared_a: assert property (clean_shared_p) else $error("clean hit not shared only");

  busy_retry_a: assert property (@(posedge sys_clk) disable iff (reset)
    (lookup & processor_side_tag_hit & inv_busy) |=> snoop_retry_status & ~need_invalidate)
    else $error("snoop during invalidate not retried");

endmodule

`default_nettype wire

// [rtl/spi_snoop_inv_ctrl.sv]
// Snoop hit to primary cache invalidate control, top module.
// Assumes both buses run on sys_clk and tag lookups are external.
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg.svh"

module spi_snoop_inv_ctrl
  import spi_pkg::*;
#(
  parameter int ADDR_W = `SPI_ADDR_W
)
(
  input  wire  logic              sys_clk,                 // System clock
  input  wire  logic              reset,                   // Synchronous reset
  input  wire  logic              ext_arb_mode,            // 1: external processor arbiter
  input  wire  logic              sys_transfer_start,      // System transfer start
  input  wire  logic              sys_global_attr,         // System global attribute
  input  wire  logic [ADDR_W-1:0] sys_addr,                // System address
  input  wire  logic              main_cache_tag_hit,      // Main tag hit, same cycle as start
  input  wire  logic              main_cache_tag_modified, // Hit line modified
  input  wire  logic              processor_side_tag_hit,  // Processor tag hit
  input  wire  logic              proc_tag_req,            // Processor wants tag lookup
  input  wire  logic              sys_arb_pending,         // Processor request arbitrating sys bus
  input  wire  logic              cpb_done,                // Snoop copyback finished
  input  wire  logic              proc_xfer_active,        // Processor transfer in progress
  input  wire  logic              proc_bus_grant_in,       // Qualified external grant
  input  wire  logic              proc_snoop_retry,        // Processor signals copyback
  input  wire  logic              proc_cpb_done,           // Processor copyback finished
  output logic                    proc_tag_grant,          // Tag granted to processor
  output logic                    snoop_shared_status,     // Shared status
  output logic                    snoop_retry_status,      // Retry status
  output logic                    snoop_copyback_status,   // Copyback status
  output logic                    proc_transfer_retry,     // Processor transfer retry
  output logic                    proc_req_restart,        // Pulse: restart retried request
  output logic                    proc_bus_request,        // Request to external arbiter
  output logic                    proc_bus_grant,          // Grant driven as arbiter
  output logic                    proc_transfer_start,     // Processor transfer start
  output logic                    proc_global_attr,        // Global attribute
  output logic                    proc_invalidate_attr,    // Invalidate attribute
  output logic [ADDR_W-1:0]       proc_addr,               // Line address
  output logic                    proc_addr_oe_n           // Address drive enable, low drives
);

  localparam logic [1:0] TENURE_LAST = 2'(`SPI_INV_TENURE_CLKS - 1);
  localparam logic [1:0] WINDOW_LAST = 2'(`SPI_CPB_WINDOW_CLKS - 1);

  spi_inv_state_t    state;
  spi_inv_state_t    next_state;
  logic [1:0]        cnt;
  logic [ADDR_W-1:0] line_addr;
  logic              lookup;
  logic              need_copyback;
  logic              need_invalidate;
  logic              inv_busy;
  logic              retried;
  logic              cpb_wait;
  logic              have_bus;
  logic              stat_sh;
  logic              stat_rt;
  logic              stat_cb;

  // ------------------------------------------------------------------
  // Tag arbitration and snoop response
  // ------------------------------------------------------------------
  assign lookup   = sys_transfer_start & sys_global_attr;
  assign inv_busy = (state != SPI_IDLE) | need_invalidate;
  assign have_bus = ext_arb_mode ? proc_bus_grant_in : 1'b1;

  spi_snoop_resp u_resp (
    .sys_clk                 (sys_clk),
    .reset                   (reset),
    .lookup                  (lookup),
    .main_cache_tag_hit      (main_cache_tag_hit),
    .main_cache_tag_modified (main_cache_tag_modified),
    .processor_side_tag_hit  (processor_side_tag_hit),
    .inv_busy                (inv_busy),
    .snoop_shared_status     (stat_sh),
    .snoop_retry_status      (stat_rt),
    .snoop_copyback_status   (stat_cb),
    .need_copyback           (need_copyback),
    .need_invalidate         (need_invalidate)
  );

  // ------------------------------------------------------------------
  // Invalidate sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      SPI_IDLE:   if (need_invalidate) begin
                    next_state = proc_xfer_active ? SPI_RETRY : SPI_REQ;
                  end
      SPI_RETRY:  next_state = SPI_REQ;
      SPI_REQ:    if (have_bus) begin
                    next_state = SPI_TENURE;
                  end
      SPI_TENURE: if (cnt == TENURE_LAST) begin
                    next_state = SPI_WINDOW;
                  end
      SPI_WINDOW: if (proc_snoop_retry) begin
                    next_state = SPI_PCPB;
                  end else if (cnt == WINDOW_LAST) begin
                    next_state = SPI_IDLE;
                  end
      SPI_PCPB:   if (proc_cpb_done) begin
                    next_state = SPI_IDLE;
                  end
      default:    next_state = SPI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state     <= SPI_IDLE;
      cnt       <= 2'h0;
      line_addr <= '0;
    end else begin
      state <= next_state;
      cnt   <= (next_state == state) ? cnt + 2'h1 : 2'h0;
      // Only the lookup that starts an invalidate may move the address
      if (lookup & processor_side_tag_hit & ~inv_busy) begin
        line_addr <= {sys_addr[ADDR_W-1:`SPI_LINE_OFFS_W], `SPI_LINE_OFFS_W'(0)};
      end
    end
  end

  // ------------------------------------------------------------------
  // Processor request retry and restart
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      retried  <= 1'b0;
      cpb_wait <= 1'b0;
    end else begin
      if ((need_copyback | need_invalidate) & sys_arb_pending) begin
        retried <= 1'b1;
      end else if (proc_req_restart) begin
        retried <= 1'b0;
      end
      if (need_copyback) begin
        cpb_wait <= 1'b1;
      end else if (cpb_done) begin
        cpb_wait <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      proc_tag_grant        <= 1'b0;
      snoop_shared_status   <= 1'b0;
      snoop_retry_status    <= 1'b0;
      snoop_copyback_status <= 1'b0;
      proc_transfer_retry   <= 1'b0;
      proc_req_restart      <= 1'b0;
      proc_bus_request      <= 1'b0;
      proc_bus_grant        <= 1'b1;
      proc_transfer_start   <= 1'b0;
      proc_global_attr      <= 1'b0;
      proc_invalidate_attr  <= 1'b0;
      proc_addr             <= '0;
      proc_addr_oe_n        <= 1'b1;
    end else begin
      proc_tag_grant        <= proc_tag_req & ~lookup;
      snoop_shared_status   <= stat_sh;
      snoop_retry_status    <= stat_rt;
      snoop_copyback_status <= stat_cb;
      proc_transfer_retry   <= ((need_copyback | need_invalidate) & sys_arb_pending)
                               | (next_state == SPI_RETRY);
      proc_req_restart      <= retried & ~cpb_wait & ~need_copyback & ~proc_req_restart
                               & (state == SPI_IDLE);
      proc_bus_request      <= ext_arb_mode & (next_state == SPI_REQ);
      proc_bus_grant        <= ext_arb_mode | (next_state == SPI_IDLE);
      proc_transfer_start   <= (state == SPI_REQ) & have_bus;
      proc_global_attr      <= next_state == SPI_TENURE;
      proc_invalidate_attr  <= next_state == SPI_TENURE;
      proc_addr             <= line_addr;
      proc_addr_oe_n        <= ~((next_state == SPI_TENURE) | (next_state == SPI_WINDOW)
                                 | (next_state == SPI_PCPB));
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence inv_start_s;
    proc_transfer_start & proc_global_attr & proc_invalidate_attr;
  endsequence

  sequence tenure_s;
    proc_global_attr [*2] ##1 ~proc_global_attr;
  endsequence

  hit_starts_inv_a: assert property (@(posedge sys_clk) disable iff (reset)
    (need_invalidate & ~proc_xfer_active & ~ext_arb_mode) |-> ##[1:4] proc_transfer_start)
    else $error("invalidate not started after tag hit");

  inv_attrs_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(proc_transfer_start) |-> inv_start_s and ~proc_addr_oe_n)
    else $error("invalidate start without attributes");

  tenure_two_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(proc_global_attr) |-> tenure_s)
    else $error("invalidate tenure not two clocks");

  hold_window_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(proc_global_attr) |-> ~proc_addr_oe_n [*3])
    else $error("bus released before copyback window");

  grant_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ext_arb_mode & proc_bus_request & ~proc_bus_grant_in) |=> ~proc_transfer_start)
    else $error("invalidate started without grant");

  arb_takes_bus_a: assert property (@(posedge sys_clk) disable iff (reset)
    (~ext_arb_mode & $rose(proc_transfer_start)) |-> ~$past(proc_bus_grant))
    else $error("grant not negated before invalidate");

  xfer_retry_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state == SPI_IDLE & need_invalidate & proc_xfer_active) |=> proc_transfer_retry)
    else $error("active transfer not retried");

  arb_retry_a: assert property (@(posedge sys_clk) disable iff (reset)
    (need_copyback & sys_arb_pending) |=> proc_transfer_retry)
    else $error("arbitrating request not retried");

  restart_a: assert property (@(posedge sys_clk) disable iff (reset)
    proc_req_restart |-> ~cpb_wait)
    else $error("restart before copyback done");

  tag_prio_a: assert property (@(posedge sys_clk) disable iff (reset)
    (lookup & proc_tag_req) |=> ~proc_tag_grant)
    else $error("processor won tag over snoop");

endmodule

`default_nettype wire

// [verification/spi_proc_model.sv]
// Processor with primary cache and external processor bus arbiter.
// Assumes it shares sys_clk and reset with the controller.
`timescale 1ns/1ps
`default_nettype none

module spi_proc_model #(
  parameter int GRANT_DLY = 3  // One less than the request cycles before grant
)
(
  input  wire logic sys_clk,              // System clock
  input  wire logic reset,                // Synchronous reset
  input  wire logic dirty,                // 1: primary line modified
  input  wire logic proc_bus_request,     // Request from controller
  input  wire logic proc_transfer_start,  // Transfer start
  input  wire logic proc_invalidate_attr, // Invalidate attribute
  output logic      proc_bus_grant_in,    // Qualified grant
  output logic      proc_snoop_retry,     // Copyback notice
  output logic      proc_cpb_done         // Copyback finished
);
  int req_cnt;
  int hold_cnt;
  int cpb_cnt;

  assign proc_bus_grant_in = hold_cnt > 0;
  assign proc_snoop_retry  = cpb_cnt == 2;
  assign proc_cpb_done     = cpb_cnt == 7;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_cnt  <= 0;
      hold_cnt <= 0;
      cpb_cnt  <= 0;
    end else begin
      // Slow grant, then held through the invalidate and window
      req_cnt <= proc_bus_request ? req_cnt + 1 : 0;
      if (proc_bus_request && req_cnt == GRANT_DLY) hold_cnt <= 12;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
      // Modified line: copyback notice in the window, done later
      if (proc_transfer_start && proc_invalidate_attr && dirty) cpb_cnt <= 1;
      else if (cpb_cnt > 0) cpb_cnt <= (cpb_cnt == 7) ? 0 : cpb_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [verification/spi_snoop_inv_ctrl_tb.sv]
// Self-checking bench for the snoop and primary invalidate control.
// Assumes spi_proc_model stands on the processor bus side.
`timescale 1ns/1ps
`default_nettype none

module spi_snoop_inv_ctrl_tb;
  import spi_pkg::*;
  logic        sys_clk = 0, reset = 1, ext_arb_mode = 0, sys_transfer_start = 0;
  logic        sys_global_attr = 0, main_cache_tag_hit = 0, main_cache_tag_modified = 0;
  logic        processor_side_tag_hit = 0, proc_tag_req = 0, sys_arb_pending = 0;
  logic        cpb_done = 0, proc_xfer_active = 0, dirty = 0;
  logic [31:0] sys_addr = 32'h0000_0000;
  logic        proc_bus_grant_in, proc_snoop_retry, proc_cpb_done, proc_tag_grant;
  logic        snoop_shared_status, snoop_retry_status, snoop_copyback_status;
  logic        proc_transfer_retry, proc_req_restart, proc_bus_request, proc_bus_grant;
  logic        proc_transfer_start, proc_global_attr, proc_invalidate_attr, proc_addr_oe_n;
  logic [31:0] proc_addr;
  int          n_fail = 0, num_checks = 0;

  always #4 sys_clk = ~sys_clk;

  spi_snoop_inv_ctrl dut_u (.sys_clk, .reset, .ext_arb_mode, .sys_transfer_start,
    .sys_global_attr, .sys_addr, .main_cache_tag_hit, .main_cache_tag_modified,
    .processor_side_tag_hit, .proc_tag_req, .sys_arb_pending, .cpb_done, .proc_xfer_active,
    .proc_bus_grant_in, .proc_snoop_retry, .proc_cpb_done, .proc_tag_grant,
    .snoop_shared_status, .snoop_retry_status, .snoop_copyback_status, .proc_transfer_retry,
    .proc_req_restart, .proc_bus_request, .proc_bus_grant, .proc_transfer_start,
    .proc_global_attr, .proc_invalidate_attr, .proc_addr, .proc_addr_oe_n);

  spi_proc_model pm_u (.sys_clk, .reset, .dirty, .proc_bus_request, .proc_transfer_start,
    .proc_invalidate_attr, .proc_bus_grant_in, .proc_snoop_retry, .proc_cpb_done);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic nx();
    @(posedge sys_clk);
    #1;
  endtask

  // Lookup inputs launched here are sampled at the next edge
  task automatic lk(input logic st, input logic hit, input logic md, input logic pt,
                    input logic [31:0] a);
    @(posedge sys_clk);
    sys_transfer_start      <= st;  // Memory ends address tenure after one clock
    sys_global_attr         <= st;  // Data held off while snoopers answer
    main_cache_tag_hit      <= hit;
    main_cache_tag_modified <= md;
    processor_side_tag_hit  <= pt;
    sys_addr                <= a;
  endtask

  task automatic wait_hi(ref logic s, input string what, input int lim);
    int n;
    for (n = 0; n < lim && s !== 1'b1; n++) nx();
    if (n == lim) begin
      $display("unexpected wait for %s: expected 1, seen timeout", what);
      n_fail++;
      finish_test();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    check("grant", proc_bus_grant, 1'b1);
    check("oe_n", proc_addr_oe_n, 1'b1);
    check("start", proc_transfer_start, 1'b0);
    check("shared", snoop_shared_status, 1'b0);
  endtask

  // Processor-side hit, back-to-back miss, then a hit while the invalidate runs
  task automatic sc_arbiter();
    lk(1, 0, 0, 1, 32'h1234_567F);
    lk(1, 0, 0, 0, 32'h0000_0040);
    lk(0, 0, 0, 0, 32'h0000_0000);
    #1;
    check("shared c2", snoop_shared_status, 1'b1);
    check("retry c2", snoop_retry_status, 1'b0);
    check("grant c2", proc_bus_grant, 1'b0);
    lk(1, 0, 0, 1, 32'h0000_0080);
    #1;
    check("miss status", {snoop_shared_status, snoop_retry_status,
          snoop_copyback_status}, 3'b000);
    check("start c3", proc_transfer_start, 1'b1);
    check("attr c3", {proc_global_attr, proc_invalidate_attr}, 2'b11);
    check("addr", proc_addr, 32'h1234_5660);
    check("oe_n c3", proc_addr_oe_n, 1'b0);
    lk(0, 0, 0, 0, 32'h0000_0000);
    #1;
    check("start c4", proc_transfer_start, 1'b0);
    check("attr c4", {proc_global_attr, proc_invalidate_attr}, 2'b11);
    for (int i = 5; i <= 7; i++) begin
      nx();
      check("oe_n window", proc_addr_oe_n, 1'b0);
      if (i == 5) check("busy retry", snoop_retry_status, 1'b1);
    end
    nx();
    check("oe_n c8", proc_addr_oe_n, 1'b1);
    check("grant c8", proc_bus_grant, 1'b1);
    for (int i = 0; i < 6; i++) begin
      nx();
      check("no second start", proc_transfer_start, 1'b0);
    end
  endtask

  // External arbiter, active transfer, modified primary line
  task automatic sc_external();
    @(posedge sys_clk);
    ext_arb_mode     <= 1;
    proc_xfer_active <= 1;
    dirty            <= 1;
    lk(1, 0, 0, 1, 32'h0000_A5C3);
    lk(0, 0, 0, 0, 32'h0000_0000);
    wait_hi(proc_transfer_retry, "transfer retry", 6);
    check("start at retry", proc_transfer_start, 1'b0);
    @(posedge sys_clk);
    proc_xfer_active <= 0;
    #1;
    check("retry pulse", proc_transfer_retry, 1'b0);
    wait_hi(proc_bus_request, "bus request", 6);
    check("start before grant", proc_transfer_start, 1'b0);
    wait_hi(proc_transfer_start, "transfer start", 12);
    check("grant seen", proc_bus_grant_in, 1'b1);
    check("ext addr", proc_addr, 32'h0000_A5C0);
    wait_hi(proc_cpb_done, "processor copyback", 12);
    check("oe_n held", proc_addr_oe_n, 1'b0);
    nx();
    nx();
    check("oe_n released", proc_addr_oe_n, 1'b1);
    @(posedge sys_clk);
    ext_arb_mode     <= 0;
    dirty            <= 0;
    proc_xfer_active <= 1;  // Retried transfer starts again
  endtask

  // Copyback hit while arbitrating, tag priority, restart after copyback
  task automatic sc_restart();
    @(posedge sys_clk);
    proc_xfer_active <= 0;
    sys_arb_pending  <= 1;
    lk(1, 1, 1, 0, 32'h0000_1000);
    proc_tag_req <= 1;
    lk(0, 0, 0, 0, 32'h0000_0000);
    #1;
    check("tag denied", proc_tag_grant, 1'b0);
    nx();
    check("tag granted", proc_tag_grant, 1'b1);
    check("copyback status", snoop_copyback_status, 1'b1);
    check("retry status", snoop_retry_status, 1'b1);
    check("proc retried", proc_transfer_retry, 1'b1);
    nx();
    check("retry one cycle", proc_transfer_retry, 1'b0);
    check("no early restart", proc_req_restart, 1'b0);
    @(posedge sys_clk);
    cpb_done        <= 1;
    sys_arb_pending <= 0;
    proc_tag_req    <= 0;
    @(posedge sys_clk);
    cpb_done <= 0;
    wait_hi(proc_req_restart, "restart", 6);
    nx();
    check("restart pulse", proc_req_restart, 1'b0);
  endtask

  // Clean secondary-only hit during a processor transfer
  task automatic sc_shared_only();
    @(posedge sys_clk);
    proc_xfer_active <= 1;
    lk(1, 1, 0, 0, 32'h0000_2000);
    lk(0, 0, 0, 0, 32'h0000_0000);
    for (int i = 1; i <= 8; i++) begin
      nx();
      check("shared only", snoop_shared_status, i == 1);
      check("no interrupt", proc_transfer_retry, 1'b0);
    end
    @(posedge sys_clk);
    proc_xfer_active <= 0;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 0;
    #1;
    sc_reset();
    sc_arbiter();
    sc_external();
    sc_restart();
    sc_shared_only();
    finish_test();
  end
endmodule
`default_nettype wire
